/* verilog/swd_pkg.sv */
// How it works
// - a one-then-zero write on the arm bit sets the counting flag
// - a one-then-zero write on the disarm bit clears the counting flag
// - a one-then-zero write on the restart bit restarts the tick count
// - unattended armed watchdog expires after count+1 to count+2 ticks
// - ticks are not resynchronised to restart, so expiry varies by one tick
// - watchdog tick is the millisecond tick divided by divider value plus one
// - power-down input high stops the watchdog; low keeps it running
package swd_pkg;
  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam logic [7:0] SWD_CTRL_ADDR = 8'hff;
  localparam logic [7:0] SWD_CTRL_RESET = 8'h00;
  localparam int SWD_ARM_POS = 7;
  localparam int SWD_DISARM_POS = 6;
  localparam int SWD_RESTART_POS = 5;
  localparam int SWD_CNT_LSB = 0;
  localparam int SWD_CNT_W = 5;
  // ************************************************************
  // tick chain
  // ************************************************************
  localparam int SWD_TICK_PERIOD_MS = 100;
  localparam int SWD_DIV_W = 7;
  localparam int SWD_TICKS_W = 6;
  localparam logic [SWD_DIV_W-1:0] SWD_DIV_RESET = 7'h00;
  localparam logic [SWD_TICKS_W-1:0] SWD_TICKS_RESET = 6'h00;
  typedef logic [7:0] swd_byte_t;
endpackage : swd_pkg

/* verilog/swd_tick_div.sv */
`timescale 1ns/1ns
module swd_tick_div
  import swd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic ms_tick_i,
  input wire logic [SWD_DIV_W-1:0] div_i,
  output logic hms_tick_o
);
  logic [SWD_DIV_W-1:0] div_cnt;
  wire last_ms = ms_tick_i && (div_cnt == div_i);

  // ************************************************************
  // divide the millisecond tick by div_i plus one
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run_i) begin
      div_cnt <= SWD_DIV_RESET;
      hms_tick_o <= 1'b0;
    end else begin
      hms_tick_o <= last_ms;
      if (ms_tick_i) begin
        div_cnt <= last_ms ? SWD_DIV_RESET : div_cnt + 7'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_tick_divide: assert property (hms_tick_o |-> $past(ms_tick_i) && $past(div_cnt) == $past(div_i))
    else $error("tick not at end of division");
  chk_tick_stopped: assert property (!run_i |=> !hms_tick_o)
    else $error("tick while powered down");
endmodule : swd_tick_div

/* verilog/swd_watchdog.sv */
`timescale 1ns/1ns
module swd_watchdog
  import swd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire swd_pkg::swd_byte_t sfr_wdata_i,
  input wire logic ms_tick_i,
  input wire logic [swd_pkg::SWD_DIV_W-1:0] hms_div_i,
  input wire logic watchdog_power_down_i,
  output swd_pkg::swd_byte_t sfr_rdata_o,
  output logic counting_o,
  output logic timeout_o
);
  import swd_pkg::*;

  // ************************************************************
  // register port and sequence detection
  // ************************************************************
  swd_byte_t watchdog_control;
  logic [SWD_TICKS_W-1:0] tick_cnt;
  logic hundred_ms_tick;
  logic [2:0] seq_fire;

  function automatic int seq_pos(input int idx);
    seq_pos = (idx == 0) ? SWD_ARM_POS : (idx == 1) ? SWD_DISARM_POS : SWD_RESTART_POS;
  endfunction : seq_pos

  wire ctrl_wr = sfr_wr_i && (sfr_addr_i == SWD_CTRL_ADDR);
  wire [SWD_CNT_W-1:0] timeout_count = watchdog_control[SWD_CNT_LSB +: SWD_CNT_W];
  wire [SWD_TICKS_W-1:0] tick_limit = {1'b0, timeout_count} + 6'h01;
  wire arm_fire = seq_fire[0];
  wire disarm_fire = seq_fire[1];
  wire restart_fire = seq_fire[2];
  wire run = !watchdog_power_down_i;
  // a restart or arm in the same cycle as the last tick wins over expiry
  wire expire = counting_o && run && hundred_ms_tick && !restart_fire && !arm_fire
                && (tick_cnt == tick_limit);
  wire next_counting = disarm_fire ? 1'b0 : (arm_fire ? 1'b1 : counting_o);
  wire count_clear = restart_fire || arm_fire || !run || !counting_o;

  // a sequence fires when a stored one is overwritten with zero
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_seq
      assign seq_fire[gi] = ctrl_wr && watchdog_control[seq_pos(gi)]
                            && !sfr_wdata_i[seq_pos(gi)];
    end
  endgenerate

  // stored control byte, read back one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      watchdog_control <= SWD_CTRL_RESET;
      sfr_rdata_o <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        watchdog_control <= sfr_wdata_i;
      end
      sfr_rdata_o <= (sfr_addr_i == SWD_CTRL_ADDR) ? watchdog_control : 8'h00;
    end
  end

  // ************************************************************
  // counting flag, tick count and expiry
  // ************************************************************
  swd_tick_div u_tick_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .ms_tick_i(ms_tick_i),
    .div_i(hms_div_i),
    .hms_tick_o(hundred_ms_tick)
  );

  // disarm wins when both sequences complete in one write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      counting_o <= 1'b0;
    end else begin
      counting_o <= next_counting;
    end
  end

  // ticks are counted as they come; restart leaves the divider alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || count_clear) begin
      tick_cnt <= SWD_TICKS_RESET;
    end else if (hundred_ms_tick) begin
      tick_cnt <= expire ? SWD_TICKS_RESET : tick_cnt + 6'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= expire;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // shadow of the three sequence bits as last written, kept apart from the
  // stored control byte so the detector is checked against its own history
  logic [2:0] shadow_bits;
  wire [2:0] written_seq_bits = {sfr_wdata_i[SWD_RESTART_POS], sfr_wdata_i[SWD_DISARM_POS],
                                 sfr_wdata_i[SWD_ARM_POS]};
  wire [2:0] shadow_done = ctrl_wr ? (shadow_bits & ~written_seq_bits) : 3'h0;

  // shadow bits follow every write to the control register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shadow_bits <= 3'h0;
    end else if (ctrl_wr) begin
      shadow_bits <= written_seq_bits;
    end
  end

  // ************************************************************
  // sequence checks
  // ************************************************************
  // counting may only start on a completed arm sequence
  chk_arm_cause: assert property ($rose(counting_o) |-> $past(arm_fire) && !$past(disarm_fire))
    else $error("counting started without arm sequence");

  // a lone write of either value never starts counting
  chk_arm_needs_seq: assert property (!counting_o && !arm_fire |=> !counting_o)
    else $error("counting started without a completed sequence");

  // an idle watchdog never expires
  chk_idle_quiet: assert property (!counting_o |=> !timeout_o)
    else $error("timeout while not counting");

  // detector fires exactly on a one overwritten with zero
  chk_seq_detect: assert property (seq_fire == shadow_done)
    else $error("sequence detection mismatch");

  // disarm stops counting
  chk_disarm_stop: assert property (disarm_fire |=> !counting_o)
    else $error("disarm sequence did not stop counting");

  // disarm beats arm when both complete in one write
  chk_disarm_wins: assert property (arm_fire && disarm_fire |=> !counting_o)
    else $error("arm overrode disarm");

  // counting only drops through a disarm sequence
  chk_flag_drop: assert property ($fell(counting_o) |-> $past(disarm_fire))
    else $error("counting stopped without disarm sequence");

  // restart clears the count and suppresses expiry
  chk_restart_zero: assert property (restart_fire |=> tick_cnt == 6'h00 && !timeout_o)
    else $error("restart did not clear tick count");

  // arming starts from a clean count as well
  chk_arm_zero: assert property (arm_fire |=> tick_cnt == 6'h00 && !timeout_o)
    else $error("arm did not clear tick count");

  // ************************************************************
  // expiry checks
  // ************************************************************
  // expiry only at the documented tick count
  chk_expiry_count: assert property (timeout_o |-> $past(tick_cnt) == $past(tick_limit))
    else $error("expiry at wrong tick count");

  // each tick advances the count by one
  chk_tick_step: assert property (hundred_ms_tick && !count_clear && !expire
                                  |=> tick_cnt == $past(tick_cnt) + 6'h01)
    else $error("tick count did not advance");

  // after expiry the count starts over
  chk_expiry_wrap: assert property (timeout_o |-> tick_cnt == 6'h00)
    else $error("tick count not cleared at expiry");

  // expiry lands on a tick of a counting watchdog
  chk_expiry_on_tick: assert property (timeout_o |-> $past(hundred_ms_tick) && $past(counting_o))
    else $error("expiry not on a tick");

  // between ticks the count holds
  chk_tick_hold: assert property (!hundred_ms_tick && !count_clear |=> $stable(tick_cnt))
    else $error("tick count moved without a tick");

  // ************************************************************
  // power-down, pulse and register checks
  // ************************************************************
  // power-down clears the count and blocks expiry
  chk_power_down: assert property (watchdog_power_down_i |=> tick_cnt == 6'h00 && !timeout_o)
    else $error("watchdog ran while powered down");

  // power-down silences the tick
  chk_tick_off_pd: assert property (watchdog_power_down_i |=> !hundred_ms_tick)
    else $error("tick while watchdog powered down");

  // timeout is a single-cycle event
  chk_pulse_single: assert property (timeout_o |=> !timeout_o)
    else $error("timeout longer than one cycle");

  // expiry leaves the counting flag alone
  chk_flag_kept: assert property (timeout_o && !$past(disarm_fire) |-> counting_o)
    else $error("expiry changed counting flag");

  // a write stores the whole byte
  chk_ctrl_store: assert property (ctrl_wr |=> watchdog_control == $past(sfr_wdata_i))
    else $error("control byte not stored");

  // stored byte reads back one cycle after the address
  chk_read_back: assert property (ctrl_wr ##1 sfr_addr_i == SWD_CTRL_ADDR
                                  |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("control byte read back wrong");

  // other addresses read as zero
  chk_other_addr: assert property (sfr_addr_i != SWD_CTRL_ADDR |=> sfr_rdata_o == 8'h00)
    else $error("foreign address returned data");

  // main scenarios
  cov_arm: cover property (arm_fire ##1 counting_o);
  cov_expire: cover property (counting_o ##[1:1000] timeout_o);
  cov_restart: cover property (counting_o && restart_fire);
  cov_disarm: cover property (counting_o ##1 disarm_fire ##1 !counting_o);
  cov_power_down: cover property (counting_o && watchdog_power_down_i ##1 !watchdog_power_down_i);
endmodule : swd_watchdog

/* verif/swd_watchdog_tb.sv */
`timescale 1ns/1ns
module tb;
  import swd_pkg::*;
  // ************************************************************
  // stimulus and design hookup
  // ************************************************************
  logic ref_clk_i = 0, rst_i = 1, sfr_wr_i = 0, ms_tick_i = 0, watchdog_power_down_i = 0;
  logic [7:0] sfr_addr_i = 8'hff;
  swd_byte_t sfr_wdata_i = 8'h00;
  swd_byte_t sfr_rdata_o;
  logic [SWD_DIV_W-1:0] hms_div_i = 7'h00;
  logic counting_o, timeout_o, hit = 0;
  int err_count = 0, samples_checked = 0, cyc = 0, n = 0;
  logic [7:0] n_tab [3] = '{8'h00, 8'h03, 8'h07};
  swd_watchdog uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .ms_tick_i(ms_tick_i),
    .hms_div_i(hms_div_i), .watchdog_power_down_i(watchdog_power_down_i),
    .sfr_rdata_o(sfr_rdata_o), .counting_o(counting_o), .timeout_o(timeout_o));
  // free-running clock
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // ************************************************************
  // tasks
  // ************************************************************
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one write cycle; address returns to the control register for reads
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    @(negedge ref_clk_i);
    sfr_wr_i = 0;
    sfr_addr_i = SWD_CTRL_ADDR;
  endtask : wr
  // one-then-zero sequence on a control bit, with count field c
  task seq(input logic [7:0] b, input logic [7:0] c);
    wr(SWD_CTRL_ADDR, b | c);
    wr(SWD_CTRL_ADDR, c);
    @(negedge ref_clk_i);
  endtask : seq
  // one ms tick, then watch for the expiry pulse
  task tick;
    ms_tick_i = 1;
    @(negedge ref_clk_i);
    ms_tick_i = 0;
    repeat (3) begin
      @(negedge ref_clk_i);
      if (timeout_o === 1'b1) hit = 1;
    end
  endtask : tick
  // n = ms ticks until expiry, 0 if none within lim
  task expire(input int lim);
    n = 0;
    hit = 0;
    for (int i = 1; i <= lim && n == 0; i++) begin
      tick();
      if (hit) n = i;
    end
  endtask : expire
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t run too long", $time);
      print_verdict();
    end
  end
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 0;
    @(negedge ref_clk_i);
    chk(sfr_rdata_o, SWD_CTRL_RESET);
    wr(SWD_CTRL_ADDR, 8'h83);
    @(negedge ref_clk_i);
    chk({7'h0, counting_o}, 8'h00);
    chk(sfr_rdata_o, 8'h83);
    wr(SWD_CTRL_ADDR, 8'h03);
    @(negedge ref_clk_i);
    chk({7'h0, counting_o}, 8'h01);
    $display("test arm done");
    foreach (n_tab[k]) begin
      seq(8'h20, n_tab[k]);
      expire(40);
      chk(8'(n), n_tab[k] + 8'h02);
      chk({7'h0, counting_o}, 8'h01);
    end
    $display("test expiry done");
    seq(8'h20, 8'h03);
    hit = 0;
    repeat (3) tick();
    chk({7'h0, hit}, 8'h00);
    seq(8'h20, 8'h03);
    expire(20);
    chk(8'(n), 8'h05);
    $display("test restart done");
    seq(8'h40, 8'h03);
    chk({7'h0, counting_o}, 8'h00);
    expire(10);
    chk(8'(n), 8'h00);
    wr(8'hfe, 8'h80);
    wr(8'hfe, 8'h00);
    sfr_addr_i = 8'hfe;
    @(negedge ref_clk_i);
    chk(sfr_rdata_o, 8'h00);
    chk({7'h0, counting_o}, 8'h00);
    sfr_addr_i = SWD_CTRL_ADDR;
    $display("test disarm done");
    seq(8'h80, 8'h01);
    watchdog_power_down_i = 1;
    expire(10);
    chk(8'(n), 8'h00);
    watchdog_power_down_i = 0;
    expire(10);
    chk(8'(n), 8'h03);
    $display("test power down done");
    hms_div_i = 7'h01;
    seq(8'h20, 8'h01);
    expire(20);
    chk({7'h0, n >= 4 && n <= 6}, 8'h01);
    $display("test divider done");
    seq(8'hc0, 8'h01);
    chk({7'h0, counting_o}, 8'h00);
    $display("test disarm wins done");
    print_verdict();
  end
endmodule : tb
